/* File: pkg/tbl_defines.vh */
`ifndef TBL_DEFINES_VH
`define TBL_DEFINES_VH

// ----------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------
`define TBL_ADDR_SECURITY   12'h000
`define TBL_ADDR_CTRL       12'h004
`define TBL_ADDR_STATUS     12'h008
`define TBL_ADDR_LENGTH     12'h00c
`define TBL_ADDR_CRC        12'h010
`define TBL_ADDR_OTP_ADDR   12'h014
`define TBL_ADDR_OTP_DATA   12'h018

// ----------------------------------------------------------------
// Security register fields
// ----------------------------------------------------------------
`define TBL_SEC_NO_DEBUG    0
`define TBL_SEC_NO_LINK     1
`define TBL_SEC_SECURE_BOOT 5
`define TBL_SEC_REDUNDANT   7
`define TBL_SEC_LOCK_LO     8
`define TBL_SEC_MASTER_LOCK 12
`define TBL_SEC_NO_SCAN_OTP 13
`define TBL_SEC_GP_MASK     32'h003f8000
`define TBL_SEC_UID_MASK    32'hffc00000
`define TBL_SEC_RESET       32'h00000000

// ----------------------------------------------------------------
// Control and status bits
// ----------------------------------------------------------------
`define TBL_CTRL_OTP_PROG   0
`define TBL_ST_DONE         0
`define TBL_ST_RUN          1
`define TBL_ST_CRC_ERR      2
`define TBL_ST_BUSY         3
`define TBL_ST_SRC_OTP      4

// ----------------------------------------------------------------
// Image and checksum constants
// ----------------------------------------------------------------
`define TBL_CRC_SKIP        32'h0d15ab1e
`define TBL_CRC_POLY        32'hedb88320
`define TBL_CRC_INIT        32'hffffffff
`define TBL_RAM_BASE        15'h0000
`define TBL_OTP_ROWS        2048
`define TBL_OTP_AW          11

// ----------------------------------------------------------------
// Timing: boot delay after reset release, 15 us least
// ----------------------------------------------------------------
`define TBL_CLK_MHZ         40
`define TBL_BOOT_DELAY_US   15
`define TBL_BOOT_DELAY_CYC  (`TBL_BOOT_DELAY_US * `TBL_CLK_MHZ)

`endif

/* File: src/tbl_otp_mem.v */
`timescale 1ns/1ps
`default_nettype none

// Four sectors of 512 rows, 32 bits each; read data is registered
module tbl_otp_mem (
  input  wire        clk_i,     // System clock
  input  wire [10:0] raddr_i,   // Read row
  output reg  [31:0] rdata_o,   // Registered read data
  input  wire        we_i,      // Program strobe
  input  wire [10:0] waddr_i,   // Program row
  input  wire [31:0] wdata_i    // Program data
);

  reg [31:0] mem [0:2047];
  integer    i;

  // Blank part: every row reads zero until programmed
  initial begin
    for (i = 0; i < 2048; i = i + 1) begin
      mem[i] = 32'h0;
    end
  end

  // One-time memory: programming only sets bits, never clears them
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= mem[waddr_i] | wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

`default_nettype wire

/* File: src/tbl_boot_loader.v */
// How it works
// - Pull-downs on all general-purpose pins while chip reset is held.
// - Boot starts a fixed delay after reset release, within 15 to 150 us.
// - With secure-boot clear, the image streams from the internal quad SPI flash.
// - Secure-boot bit picks one-time memory; otherwise internal flash.
// - Secure boot reads one-time memory from row 0, bypassing boot ROM.
// - First word is program length in words; then four times that in bytes.
// - A check word follows; 0x0D15AB1E skips the comparison.
// - Length and check words arrive least significant byte first.
// - Program is written from lowest RAM address and started there.
// - Checksum covers length word and program bytes, not the check word.
// - Reflected polynomial 0xEDB88320, preset all ones, result inverted.
// - Security bit 0 refuses all debug-port access to tile state and memory.
// - Security bit 1 denies other tiles access through the switch.
// - Security bit 7 enables redundant rows of one-time memory.
// - Security bits 8 to 11 lock programming of sectors 0 to 3.
// - Security bit 12 locks all programming, including the security register.
// - Security bit 13 blocks debug-port reads and writes of one-time memory.
// - Security bits 21 to 15 are software general-purpose bits.
// - Security bits 31 to 22 extend the debug user identification code.
// - Security register loads from one-time memory before the boot choice.
// - One-time memory is four sectors of 512 rows of 32 bits.
`include "tbl_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tbl_boot_loader (
  input  wire        SYS_CLK_I,         // 40 MHz system clock
  input  wire        RST_I,             // Async reset, active high
  input  wire        CHIP_RST_N_I,      // Chip reset pin, active low
  output wire        GPIO_PULLDOWN_O,   // Pull-down enable for all pins
  // APB slave
  input  wire        PSEL_I,            // Select
  input  wire        PENABLE_I,         // Access phase
  input  wire        PWRITE_I,          // Write
  input  wire [11:0] PADDR_I,           // Byte address
  input  wire [31:0] PWDATA_I,          // Write data
  output wire        PREADY_O,          // Always ready
  output reg  [31:0] PRDATA_O,          // Read data
  output wire        PSLVERR_O,         // Unmapped address
  // Quad SPI flash on tile 0 ports
  output reg         QSPI_CS_N_O,       // Chip select, active low
  output reg         QSPI_SCLK_O,       // Serial clock
  output reg         QSPI_MOSI_O,       // Held low; no command or address is sent
  input  wire        QSPI_MISO_I,       // Data in
  // Program RAM write port
  output reg         RAM_WE_O,          // Word write strobe
  output reg  [14:0] RAM_ADDR_O,        // Word address
  output reg  [31:0] RAM_WDATA_O,       // Word data
  output reg         CPU_RUN_O,         // Start execution
  output reg  [14:0] CPU_START_ADDR_O,  // Start address
  // Security gates
  output wire        DEBUG_ALLOW_O,     // Debug access to tile state
  output wire        LINK_ALLOW_O,      // Switch access from other tiles
  output wire        DEBUG_OTP_ALLOW_O, // Debug access to one-time memory
  output wire        OTP_REDUNDANT_O,   // Redundant rows enabled
  output wire [9:0]  USER_ID_EXT_O,     // User identification extension
  // Debug-port one-time memory requests
  input  wire        DBG_OTP_REQ_I,     // Debug program request
  input  wire [10:0] DBG_OTP_ADDR_I,    // Debug row
  input  wire [31:0] DBG_OTP_WDATA_I    // Debug data
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [7:0] S_HOLD = 8'h01;
  localparam [7:0] S_SEC  = 8'h02;
  localparam [7:0] S_WAIT = 8'h04;
  localparam [7:0] S_LEN  = 8'h08;
  localparam [7:0] S_BODY = 8'h10;
  localparam [7:0] S_CHK  = 8'h20;
  localparam [7:0] S_RUN  = 8'h40;
  localparam [7:0] S_FAIL = 8'h80;

  reg  [7:0]  state_q;
  reg  [1:0]  rst_sync_q;
  reg  [1:0]  miso_sync_q;
  reg  [31:0] sec_q;
  reg  [31:0] len_q;
  reg  [31:0] word_q;
  reg  [31:0] crc_q;
  reg  [31:0] words_q;
  reg  [15:0] dly_q;
  reg  [5:0]  bit_q;
  reg  [2:0]  phase_q;
  reg  [1:0]  bcnt_q;
  reg  [10:0] otp_ptr_q;
  reg         otp_wait_q;
  reg         src_otp_q;
  reg         crc_err_q;
  reg         done_q;
  reg         ctrl_prog_q;
  reg  [10:0] prog_addr_q;
  reg  [6:0]  byte_q;

  wire [31:0] otp_rdata;
  wire        reset_held = ~rst_sync_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Chip reset and flash data are asynchronous to the system clock
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_sync_q  <= 2'h0;
      miso_sync_q <= 2'h0;
    end else begin
      rst_sync_q  <= {rst_sync_q[0], CHIP_RST_N_I};
      miso_sync_q <= {miso_sync_q[0], QSPI_MISO_I};
    end
  end

  // Pull-downs follow the synchronised reset
  assign GPIO_PULLDOWN_O = reset_held;

  // ----------------------------------------------------------------
  // One-time memory programming and gating
  // ----------------------------------------------------------------
  wire       sw_prog   = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == `TBL_ADDR_OTP_DATA);
  wire       dbg_prog  = DBG_OTP_REQ_I & ~sec_q[`TBL_SEC_NO_SCAN_OTP];
  wire [10:0] wr_row   = dbg_prog ? DBG_OTP_ADDR_I : prog_addr_q;
  wire [31:0] wr_data  = dbg_prog ? DBG_OTP_WDATA_I : PWDATA_I;
  // Sector is the top two row bits; locks are bits 8..11 in order
  wire       sec_lock  = sec_q[`TBL_SEC_LOCK_LO + wr_row[10:9]];
  wire       prog_ok   = ~sec_q[`TBL_SEC_MASTER_LOCK] & ~sec_lock & ctrl_prog_q;
  wire       otp_we    = (sw_prog | dbg_prog) & prog_ok & (state_q == S_RUN || state_q == S_FAIL);

  tbl_otp_mem u_otp (
    .clk_i   (SYS_CLK_I),
    .raddr_i (otp_ptr_q),
    .rdata_o (otp_rdata),
    .we_i    (otp_we),
    .waddr_i (wr_row),
    .wdata_i (wr_data)
  );

  assign DEBUG_ALLOW_O     = ~sec_q[`TBL_SEC_NO_DEBUG];
  assign LINK_ALLOW_O      = ~sec_q[`TBL_SEC_NO_LINK];
  assign DEBUG_OTP_ALLOW_O = ~sec_q[`TBL_SEC_NO_SCAN_OTP];
  assign OTP_REDUNDANT_O   = sec_q[`TBL_SEC_REDUNDANT];
  assign USER_ID_EXT_O     = sec_q[31:22];

  // ----------------------------------------------------------------
  // CRC over one byte, reflected
  // ----------------------------------------------------------------
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  b;
    integer i;
    reg [31:0] r;
    begin
      r = c ^ {24'h000000, b};
      for (i = 0; i < 8; i = i + 1) begin
        r = r[0] ? ((r >> 1) ^ `TBL_CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  // ----------------------------------------------------------------
  // Byte source: flash bit-serial or one-time memory rows
  // ----------------------------------------------------------------
  // Flash: SCLK toggles every 8 cycles, bits sampled MSB first per byte
  wire        collecting = (state_q == S_LEN) | (state_q == S_BODY) | (state_q == S_CHK);
  wire        flash_byte = ~src_otp_q & collecting & (phase_q == 3'h7) & QSPI_SCLK_O
                           & (bit_q[2:0] == 3'h7);
  wire [7:0]  flash_val  = {byte_q, miso_sync_q[1]};
  wire        otp_word   = src_otp_q & collecting & otp_wait_q;
  // Assemble flash words LSB first; one-time memory rows are used whole
  wire [31:0] asm_word   = {flash_val, word_q[31:8]};
  wire        word_end   = otp_word | (flash_byte & (bcnt_q == 2'h3));
  wire [31:0] new_word   = otp_word ? otp_rdata : asm_word;

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q     <= S_HOLD;
      sec_q       <= `TBL_SEC_RESET;
      len_q       <= 32'h0;
      word_q      <= 32'h0;
      crc_q       <= `TBL_CRC_INIT;
      byte_q      <= 7'h0;
      words_q     <= 32'h0;
      dly_q       <= 16'h0;
      bit_q       <= 6'h0;
      phase_q     <= 3'h0;
      bcnt_q      <= 2'h0;
      otp_ptr_q   <= 11'h0;
      otp_wait_q  <= 1'b0;
      src_otp_q   <= 1'b0;
      crc_err_q   <= 1'b0;
      done_q      <= 1'b0;
      QSPI_CS_N_O <= 1'b1;
      QSPI_SCLK_O <= 1'b0;
      QSPI_MOSI_O <= 1'b0;
      RAM_WE_O    <= 1'b0;
      RAM_ADDR_O  <= `TBL_RAM_BASE;
      RAM_WDATA_O <= 32'h0;
      CPU_RUN_O   <= 1'b0;
      CPU_START_ADDR_O <= `TBL_RAM_BASE;
    end else begin
      RAM_WE_O <= 1'b0;
      if (reset_held) begin
        state_q     <= S_HOLD;
        CPU_RUN_O   <= 1'b0;
        QSPI_CS_N_O <= 1'b1;
        QSPI_SCLK_O <= 1'b0;
        done_q      <= 1'b0;
        crc_err_q   <= 1'b0;
        otp_ptr_q   <= 11'h0;
        otp_wait_q  <= 1'b0;
      end else begin
        case (state_q)
          S_HOLD: begin
            // Fetch security row before any source decision
            otp_ptr_q  <= 11'h0;
            otp_wait_q <= 1'b1;
            state_q    <= S_SEC;
          end
          S_SEC: begin
            sec_q      <= otp_rdata;
            otp_wait_q <= 1'b0;
            dly_q      <= 16'h0;
            state_q    <= S_WAIT;
          end
          S_WAIT: begin
            // Internal reset delay before fetching the image
            dly_q <= dly_q + 16'h1;
            if (dly_q == `TBL_BOOT_DELAY_CYC - 1) begin
              src_otp_q <= sec_q[`TBL_SEC_SECURE_BOOT];
              otp_ptr_q <= 11'h0;
              crc_q     <= `TBL_CRC_INIT;
              bcnt_q    <= 2'h0;
              bit_q     <= 6'h0;
              phase_q   <= 3'h0;
              RAM_ADDR_O <= `TBL_RAM_BASE;
              QSPI_CS_N_O <= sec_q[`TBL_SEC_SECURE_BOOT];
              state_q   <= S_LEN;
            end
          end
          S_LEN, S_BODY, S_CHK: begin
            if (src_otp_q) begin
              // Registered read: issue row, use data next cycle
              otp_wait_q <= ~otp_wait_q;
              if (otp_wait_q) begin
                otp_ptr_q <= otp_ptr_q + 11'h1;
              end
            end else begin
              // Flash read: data clocks out from address 0 continuously
              phase_q <= phase_q + 3'h1;
              if (phase_q == 3'h7) begin
                QSPI_SCLK_O <= ~QSPI_SCLK_O;
                if (QSPI_SCLK_O) begin
                  bit_q  <= bit_q + 6'h1;
                  byte_q <= {byte_q[5:0], miso_sync_q[1]};
                end
              end
              if (flash_byte) begin
                word_q <= asm_word;
                bcnt_q <= bcnt_q + 2'h1;
                if (state_q != S_CHK) begin
                  crc_q <= crc_byte(crc_q, flash_val);
                end
              end
            end
            if (word_end) begin
              word_q <= new_word;
              if (src_otp_q && state_q != S_CHK) begin
                crc_q <= crc_byte(crc_byte(crc_byte(crc_byte(crc_q,
                         new_word[7:0]), new_word[15:8]), new_word[23:16]),
                         new_word[31:24]);
              end
              if (state_q == S_LEN) begin
                len_q   <= new_word;
                words_q <= 32'h0;
                state_q <= (new_word == 32'h0) ? S_CHK : S_BODY;
              end else if (state_q == S_BODY) begin
                RAM_WE_O    <= 1'b1;
                RAM_WDATA_O <= new_word;
                RAM_ADDR_O  <= words_q[14:0];
                words_q     <= words_q + 32'h1;
                if (words_q + 32'h1 == len_q) begin
                  state_q <= S_CHK;
                end
              end else begin
                QSPI_CS_N_O <= 1'b1;
                if (new_word == `TBL_CRC_SKIP || new_word == ~crc_q) begin
                  state_q <= S_RUN;
                end else begin
                  state_q <= S_FAIL;
                end
              end
            end
          end
          S_RUN: begin
            done_q           <= 1'b1;
            CPU_START_ADDR_O <= `TBL_RAM_BASE;
            CPU_RUN_O        <= 1'b1;
          end
          S_FAIL: begin
            // Program stays stopped
            done_q    <= 1'b1;
            crc_err_q <= 1'b1;
            CPU_RUN_O <= 1'b0;
          end
          default: begin
            state_q <= S_HOLD;
          end
        endcase
      end
      // Software may touch only the general-purpose bits
      if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `TBL_ADDR_SECURITY
          && !sec_q[`TBL_SEC_MASTER_LOCK]) begin
        sec_q <= (sec_q & ~`TBL_SEC_GP_MASK) | (PWDATA_I & `TBL_SEC_GP_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  wire addr_ok = (PADDR_I[1:0] == 2'h0) & (PADDR_I <= `TBL_ADDR_OTP_DATA);

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

  // Control and programming address
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_prog_q <= 1'b0;
      prog_addr_q <= 11'h0;
    end else if (PSEL_I && PENABLE_I && PWRITE_I) begin
      if (PADDR_I == `TBL_ADDR_CTRL) begin
        ctrl_prog_q <= PWDATA_I[`TBL_CTRL_OTP_PROG];
      end
      if (PADDR_I == `TBL_ADDR_OTP_ADDR) begin
        prog_addr_q <= PWDATA_I[10:0];
      end
    end
  end

  // Read data registered in the setup cycle, valid in the access phase
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I)
        `TBL_ADDR_SECURITY: PRDATA_O <= sec_q;
        `TBL_ADDR_CTRL:     PRDATA_O <= {31'h0, ctrl_prog_q};
        `TBL_ADDR_STATUS:   PRDATA_O <= {27'h0, src_otp_q, ~done_q, crc_err_q,
                                         CPU_RUN_O, done_q};
        `TBL_ADDR_LENGTH:   PRDATA_O <= len_q;
        `TBL_ADDR_CRC:      PRDATA_O <= ~crc_q;
        `TBL_ADDR_OTP_ADDR: PRDATA_O <= {21'h0, prog_addr_q};
        default:            PRDATA_O <= 32'h0;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: bench/tbl_boot_loader_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbl_defines.vh"
// ------------------------------------------------------------
// Port checker for the tile boot loader
// ------------------------------------------------------------
module tbl_boot_loader_checker (
  input wire logic        SYS_CLK_I,         // Clock
  input wire logic        RST_I,             // Reset
  input wire logic        CHIP_RST_N_I,      // Chip reset pin
  input wire logic        GPIO_PULLDOWN_O,   // Pull-down enable
  input wire logic        PSEL_I,            // Select
  input wire logic        PENABLE_I,         // Access phase
  input wire logic        PWRITE_I,          // Write
  input wire logic [11:0] PADDR_I,           // Address
  input wire logic [31:0] PRDATA_O,          // Read data
  input wire logic        PSLVERR_O,         // Bus error
  input wire logic        QSPI_CS_N_O,       // Flash select
  input wire logic        RAM_WE_O,          // RAM strobe
  input wire logic [14:0] RAM_ADDR_O,        // RAM address
  input wire logic        CPU_RUN_O,         // Run
  input wire logic [14:0] CPU_START_ADDR_O,  // Start address
  input wire logic        DEBUG_ALLOW_O,     // Debug gate
  input wire logic        LINK_ALLOW_O,      // Link gate
  input wire logic        DEBUG_OTP_ALLOW_O, // Debug memory gate
  input wire logic        OTP_REDUNDANT_O,   // Redundant rows
  input wire logic [9:0]  USER_ID_EXT_O      // Id extension
);
  logic [12:0] rel_q;  // Cycles since chip reset release
  logic        seen_q; // A RAM word was written
  logic [14:0] next_q; // Address the next word must use
  // Saturate, not wrap, so a very late boot still reads as late
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rel_q  <= 13'h0000;
      seen_q <= 1'b0;
      next_q <= 15'h0000;
    end else begin
      rel_q <= !CHIP_RST_N_I ? 13'h0000 : (&rel_q ? rel_q : rel_q + 13'h0001);
      if (RAM_WE_O) begin
        seen_q <= 1'b1;
        next_q <= RAM_ADDR_O + 15'h0001;
      end
    end
  end
  default clocking dc @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // Completed read of the security word
  sequence sec_rd;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == `TBL_ADDR_SECURITY;
  endsequence
  pull_in_reset_a: assert property (!CHIP_RST_N_I [*3] |-> GPIO_PULLDOWN_O)
    else $error("pull-down off in reset");
  boot_window_a: assert property ($fell(QSPI_CS_N_O) |-> rel_q >= 13'h0258 && rel_q <= 13'h1770)
    else $error("boot delay wrong");
  ram_word_order_a: assert property (RAM_WE_O |-> RAM_ADDR_O == (seen_q ? next_q : 15'h0000))
    else $error("word order wrong");
  start_at_base_a: assert property ($rose(CPU_RUN_O) |-> CPU_START_ADDR_O == 15'h0000 && QSPI_CS_N_O)
    else $error("start address not base");
  debug_gate_a: assert property (sec_rd |-> DEBUG_ALLOW_O == !PRDATA_O[0])
    else $error("debug gate wrong");
  link_gate_a: assert property (sec_rd |-> LINK_ALLOW_O == !PRDATA_O[1])
    else $error("link gate wrong");
  redundant_rows_a: assert property (sec_rd |-> OTP_REDUNDANT_O == PRDATA_O[7])
    else $error("redundant row enable wrong");
  debug_mem_gate_a: assert property (sec_rd |-> DEBUG_OTP_ALLOW_O == !PRDATA_O[13])
    else $error("debug memory gate wrong");
  user_id_ext_a: assert property (sec_rd |-> USER_ID_EXT_O == PRDATA_O[31:22])
    else $error("id extension wrong");
  bus_error_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == (PADDR_I > 12'h018))
    else $error("bus error flag wrong");
  cover property ($rose(CPU_RUN_O));
  cover property (RAM_WE_O);
  cover property (PSEL_I && PENABLE_I && PSLVERR_O);
endmodule

bind tbl_boot_loader tbl_boot_loader_checker tbl_boot_loader_checker_i (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CHIP_RST_N_I(CHIP_RST_N_I),
  .GPIO_PULLDOWN_O(GPIO_PULLDOWN_O), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
  .QSPI_CS_N_O(QSPI_CS_N_O), .RAM_WE_O(RAM_WE_O), .RAM_ADDR_O(RAM_ADDR_O),
  .CPU_RUN_O(CPU_RUN_O), .CPU_START_ADDR_O(CPU_START_ADDR_O), .DEBUG_ALLOW_O(DEBUG_ALLOW_O),
  .LINK_ALLOW_O(LINK_ALLOW_O), .DEBUG_OTP_ALLOW_O(DEBUG_OTP_ALLOW_O),
  .OTP_REDUNDANT_O(OTP_REDUNDANT_O), .USER_ID_EXT_O(USER_ID_EXT_O));
`default_nettype wire

/* File: bench/tbl_qspi_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Boot flash: plain read stream from select, MSB first
// ------------------------------------------------------------
module tbl_qspi_flash_model (
  input  wire logic cs_n_i, // Select, active low
  input  wire logic sclk_i, // Serial clock from loader
  output var  logic miso_o  // Serial data to loader
);
  logic [7:0] mem [0:63]; // Image bytes in stream order
  int         bit_q = 0;  // Next bit of the stream
  initial miso_o = 1'b0;
  // Restart the stream on each select
  always @(negedge cs_n_i) begin
    bit_q = 0;
    miso_o = mem[0][7];
  end
  // Shift on falling clock so data holds through a full period
  always @(negedge sclk_i) begin
    if (!cs_n_i) begin
      bit_q = bit_q + 1;
      miso_o = mem[(bit_q / 8) % 64][7 - bit_q % 8];
    end
  end
  // Released line shows the inverse of the last bit driven
  always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule
`default_nettype wire

/* File: bench/tbl_boot_loader_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbl_defines.vh"
// ------------------------------------------------------------
// Boot loader bench
// ------------------------------------------------------------
module tbl_boot_loader_tb_top;
  localparam logic [31:0] SEC_V = 32'ha94030a3; // Gates, secure boot, lock, id 2a5
  logic        clk = 1'b0, rst = 1'b1, chip_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, wdata, rd, exp_crc;
  logic        pull, pready, pslverr, cs_n, sclk, miso, we, run, dbg, lnk, dotp, red, err;
  logic [14:0] addr, start;
  logic [9:0]  uid;
  logic [14:0] wa [$];
  logic [31:0] wd [$];
  int          n_errors = 0, samples_checked = 0, dly;
  int          sz [3] = '{3, 0, 1};
  always #12.5 clk = ~clk;
  tbl_boot_loader tbl_boot_loader_i (
    .SYS_CLK_I(clk), .RST_I(rst), .CHIP_RST_N_I(chip_n), .GPIO_PULLDOWN_O(pull),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .QSPI_CS_N_O(cs_n),
    .QSPI_SCLK_O(sclk), .QSPI_MOSI_O(), .QSPI_MISO_I(miso), .RAM_WE_O(we),
    .RAM_ADDR_O(addr), .RAM_WDATA_O(wdata), .CPU_RUN_O(run), .CPU_START_ADDR_O(start),
    .DEBUG_ALLOW_O(dbg), .LINK_ALLOW_O(lnk), .DEBUG_OTP_ALLOW_O(dotp),
    .OTP_REDUNDANT_O(red), .USER_ID_EXT_O(uid), .DBG_OTP_REQ_I(1'b0),
    .DBG_OTP_ADDR_I(11'h000), .DBG_OTP_WDATA_I(32'h0));
  tbl_qspi_flash_model tbl_qspi_flash_model_i (.cs_n_i(cs_n), .sclk_i(sclk), .miso_o(miso));
  // Log every program word written
  always @(posedge clk) begin
    if (we === 1'b1) begin
      wa.push_back(addr);
      wd.push_back(wdata);
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang(input string s);
    n_errors++;
    $display("[FAIL] %0t timeout %s", $time, s);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // One transfer; request held until ready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hang("bus");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ `TBL_CRC_POLY : r >> 1;
    return r;
  endfunction
  // Image: size LSB first, body, check word; m 0 good, 1 skip, 2 corrupt
  task automatic load_image(input int s, input int m);
    logic [7:0]  b [$];
    logic [31:0] c;
    c = 32'(s);
    for (int i = 0; i < 4; i++) b.push_back(c[8*i +: 8]);
    for (int i = 0; i < 4 * s; i++) b.push_back(8'((i / 4 + 1) * 17));
    c = `TBL_CRC_INIT;
    foreach (b[j]) c = crc_byte(c, b[j]);
    exp_crc = ~c;
    c = (m == 1) ? `TBL_CRC_SKIP : exp_crc ^ {31'h0, m == 2};
    for (int i = 0; i < 4; i++) b.push_back(c[8*i +: 8]);
    foreach (b[j]) tbl_qspi_flash_model_i.mem[j] = b[j];
  endtask
  task automatic wait_cs(input logic v);
    dly = 0;
    while (cs_n !== v && dly < 8000) begin
      @(posedge clk);
      dly++;
    end
    if (cs_n !== v) hang("flash select");
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    chip_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wa.delete();
    wd.delete();
    repeat (4) @(posedge clk);
    chk(pull, 1, "pull-down in reset");
  endtask
  initial begin
    int n;
    // Good, skip with empty body, corrupt check word
    for (int m = 0; m < 3; m++) begin
      reset_dut();
      load_image(sz[m], m);
      chip_n <= 1'b1;
      wait_cs(1'b0);
      chk(32'(dly >= 600 && dly <= 6000), 1, "boot delay");
      wait_cs(1'b1);
      n = 0;
      do begin
        apb(`TBL_ADDR_STATUS, 1'b0, 32'h0);
        n++;
      end while (rd[0] !== 1'b1 && n < 200);
      if (rd[0] !== 1'b1) hang("boot done");
      chk(rd[4:2], {2'b00, m == 2}, "status bits");
      chk(run, m != 2, "cpu run");
      chk(start, 0, "start address");
      chk(pull, 0, "pull-down released");
      chk(wa.size(), sz[m], "word count");
      foreach (wa[i]) chk(wa[i], i, "ram address");
      foreach (wd[i]) chk(wd[i], {4{8'((i + 1) * 17)}}, "ram data");
      if (m == 0) begin
        apb(`TBL_ADDR_LENGTH, 1'b0, 32'h0);
        chk(rd, 3, "length");
        apb(`TBL_ADDR_CRC, 1'b0, 32'h0);
        chk(rd, exp_crc, "checksum");
      end
    end
    // Only the software bits take a write
    apb(`TBL_ADDR_SECURITY, 1'b1, 32'hffffffff);
    apb(`TBL_ADDR_SECURITY, 1'b0, 32'h0);
    chk(rd, `TBL_SEC_GP_MASK, "software bits");
    chk({dbg, lnk, dotp, red}, 4'b1110, "gates open");
    apb(12'h01c, 1'b0, 32'h0);
    chk(err, 1, "unmapped error");
    // Program the security row, then boot from it
    apb(`TBL_ADDR_CTRL, 1'b1, 32'h1);
    apb(`TBL_ADDR_OTP_ADDR, 1'b1, 32'h0);
    apb(`TBL_ADDR_OTP_DATA, 1'b1, SEC_V);
    reset_dut();
    chip_n <= 1'b1;
    repeat (700) @(posedge clk);
    chk(cs_n, 1, "flash bypassed");
    apb(`TBL_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[4], 1, "source one-time");
    apb(`TBL_ADDR_SECURITY, 1'b0, 32'h0);
    chk(rd, SEC_V, "loaded security");
    chk({dbg, lnk, dotp, red}, 4'b0001, "gates closed");
    chk(uid, 10'h2a5, "id extension");
    apb(`TBL_ADDR_SECURITY, 1'b1, 32'hffffffff);
    apb(`TBL_ADDR_SECURITY, 1'b0, 32'h0);
    chk(rd, SEC_V, "master lock");
    stop_test();
  end
endmodule
`default_nettype wire
